// >>> gate_drive_commutation.sv
// three-phase gate control with dead time, blanking and driver faults
// assumes an Avalon-MM master with waitrequest, synchronous pins, 100 MHz
`timescale 1ns/100ps
// Overview of operation
// - both inputs of one half-bridge on turns both gate outputs off.
// - break-before-make delay before any gate on, 250 to 2000 ns.
// - dead time applied internally so inverted inputs never overlap gates.
// - blanking interval selectable 500 ns, 1, 2 or 4 us, reset 4 us.
// - blanking timer starts only once the dead time has expired.
// - current spikes during blanking raise no overcurrent fault.
// - undervoltage fault latches after qualification time, extended by blanking.
// - output enable low holds all six gate outputs low.
// - high gate input switches gate on, low switches it off.
// - fault, long output-enable low or sleep force all gates low.
module gate_drive_commutation #(
   parameter int OE_LONG_CYC = gate_drive_pkg::OE_LONG_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic output_enable,
   input wire logic [2:0] high_gate_in,
   input wire logic [2:0] low_gate_in,
   input wire logic [2:0] current_spike,
   input wire logic bias_undervolt,
   output logic [2:0] high_gate_q,
   output logic [2:0] low_gate_q
);
   logic waitrequest_q;
   logic [31:0] readdata_q;
   logic [2:0] dead_time_select_q;
   logic [1:0] blanking_time_select_q;
   logic sleep_q;
   logic uvlo_en_q;
   logic oc_en_q;
   logic uv_fault_q;
   logic oc_fault_q;
   logic oe_low_long_q;
   logic [16:0] oe_low_cnt_q;
   logic [7:0] uv_cnt_q;
   logic [7:0] dead_cycles;
   logic [8:0] blank_cycles;
   logic [2:0] blank_active;
   logic enable;
   logic uv_active;
   logic oc_hit;
   logic bus_ack;
   logic [31:0] status_word;
   logic [31:0] config_word;

   // ----------------------------------------------------------------
   // timing decode
   // ----------------------------------------------------------------
   assign dead_cycles = 8'((8'(dead_time_select_q) + 8'h01) * gate_drive_pkg::DEAD_STEP_CYC);
   always_comb begin
      unique case (blanking_time_select_q)
         2'h0: blank_cycles = gate_drive_pkg::BLANK_0_CYC;
         2'h1: blank_cycles = gate_drive_pkg::BLANK_1_CYC;
         2'h2: blank_cycles = gate_drive_pkg::BLANK_2_CYC;
         2'h3: blank_cycles = gate_drive_pkg::BLANK_3_CYC;
      endcase
   end

   // gates run only when enabled, fault free and awake
   assign enable = output_enable & ~uv_fault_q & ~oc_fault_q & ~sleep_q & ~oe_low_long_q;

   // ----------------------------------------------------------------
   // half-bridge channels
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_phase
      gate_phase_channel u_chan (
         .clock(clock),
         .srst(srst),
         .enable(enable),
         .high_in(high_gate_in[i]),
         .low_in(low_gate_in[i]),
         .dead_cycles(dead_cycles),
         .blank_cycles(blank_cycles),
         .high_q(high_gate_q[i]),
         .low_q(low_gate_q[i]),
         .blank_active(blank_active[i])
      );
   end

   // ----------------------------------------------------------------
   // output enable watchdog
   // ----------------------------------------------------------------
   // low for longer than the limit drops to standby until enable returns
   always_ff @(posedge clock) begin
      if (srst || output_enable) begin
         oe_low_cnt_q <= 17'h00000;
         oe_low_long_q <= 1'b0;
      end else if (oe_low_cnt_q >= 17'(OE_LONG_CYC)) begin
         oe_low_long_q <= 1'b1;
      end else begin
         oe_low_cnt_q <= oe_low_cnt_q + 17'h00001;
      end
   end

   // ----------------------------------------------------------------
   // driver faults
   // ----------------------------------------------------------------
   // only spikes on a driven gate outside its blanking are judged
   assign oc_hit = oc_en_q & (|(current_spike & (high_gate_q | low_gate_q) & ~blank_active));
   assign uv_active = uvlo_en_q & bias_undervolt & (|(high_gate_q | low_gate_q));

   // qualification counter holds while any blanking runs
   always_ff @(posedge clock) begin
      if (srst || !uv_active) begin
         uv_cnt_q <= 8'h00;
      end else if (!(|blank_active) && uv_cnt_q != gate_drive_pkg::UV_QUAL_CYC) begin
         uv_cnt_q <= uv_cnt_q + 8'h01;
      end
   end

   // latched until output enable is dropped; set outranks clear
   always_ff @(posedge clock) begin
      if (srst) begin
         uv_fault_q <= 1'b0;
         oc_fault_q <= 1'b0;
      end else begin
         if (uv_active && uv_cnt_q == gate_drive_pkg::UV_QUAL_CYC) begin
            uv_fault_q <= 1'b1;
         end else if (!output_enable) begin
            uv_fault_q <= 1'b0;
         end
         if (oc_hit) begin
            oc_fault_q <= 1'b1;
         end else if (!output_enable) begin
            oc_fault_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // every access answers one cycle after it is seen; waitrequest rests high otherwise
   assign bus_ack = (read | write) & waitrequest_q;
   always_ff @(posedge clock) begin
      if (srst) begin
         waitrequest_q <= 1'b1;
      end else begin
         waitrequest_q <= ~bus_ack;
      end
   end

   assign config_word = {21'h000000, oc_en_q, uvlo_en_q, sleep_q, 2'h0, blanking_time_select_q,
                         1'b0, dead_time_select_q};
   assign status_word = {17'h00000, low_gate_q, 1'b0, high_gate_q, 1'b0, blank_active,
                         1'b0, oe_low_long_q, oc_fault_q, uv_fault_q};

   // read data captured on the accepting cycle; unmapped reads give zero
   always_ff @(posedge clock) begin
      if (srst) begin
         readdata_q <= 32'h00000000;
      end else if (bus_ack && read) begin
         if (address == gate_drive_pkg::REG_CONFIG_ADDR) begin
            readdata_q <= config_word;
         end else if (address == gate_drive_pkg::REG_STATUS_ADDR) begin
            readdata_q <= status_word;
         end else begin
            readdata_q <= 32'h00000000;
         end
      end
   end

   // driver_config_word_2 written at the edge that completes the access
   always_ff @(posedge clock) begin
      if (srst) begin
         dead_time_select_q <= gate_drive_pkg::DEAD_RESET;
         blanking_time_select_q <= gate_drive_pkg::BLANK_RESET;
         sleep_q <= 1'b0;
         uvlo_en_q <= 1'b1;
         oc_en_q <= 1'b1;
      end else if (write && !waitrequest_q && address == gate_drive_pkg::REG_CONFIG_ADDR) begin
         dead_time_select_q <= writedata[gate_drive_pkg::CFG_DEAD_LSB +: 3];
         blanking_time_select_q <= writedata[gate_drive_pkg::CFG_BLANK_LSB +: 2];
         sleep_q <= writedata[gate_drive_pkg::CFG_SLEEP_BIT];
         uvlo_en_q <= writedata[gate_drive_pkg::CFG_UVLO_EN_BIT];
         oc_en_q <= writedata[gate_drive_pkg::CFG_OC_EN_BIT];
      end
   end

   assign waitrequest = waitrequest_q;
   assign readdata = readdata_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_OE_LOW_OFF: assert property (@(posedge clock) disable iff (srst)
      !output_enable ##1 !output_enable |-> high_gate_q == 3'h0 && low_gate_q == 3'h0)
      else $error("gate on with output enable low");
   AST_FAULT_OFF: assert property (@(posedge clock) disable iff (srst)
      (uv_fault_q || oc_fault_q || sleep_q) |=> high_gate_q == 3'h0 && low_gate_q == 3'h0)
      else $error("gate on during fault or sleep");
   AST_OC_CAUSE: assert property (@(posedge clock) disable iff (srst)
      $rose(oc_fault_q) |-> $past(|(current_spike & (high_gate_q | low_gate_q) & ~blank_active)))
      else $error("overcurrent latched from a blanked or idle gate");
   AST_UV_QUAL: assert property (@(posedge clock) disable iff (srst)
      $rose(uv_fault_q) |-> $past(uv_cnt_q) == gate_drive_pkg::UV_QUAL_CYC)
      else $error("undervolt latched before qualification");
   AST_UV_HOLD_BLANK: assert property (@(posedge clock) disable iff (srst)
      (uv_active && (|blank_active)) ##1 uv_active |-> $stable(uv_cnt_q))
      else $error("undervolt qualification advanced during blanking");
   AST_DEAD_MAP: assert property (@(posedge clock) disable iff (srst)
      dead_cycles == 8'(({5'h00, dead_time_select_q} + 8'h01) * 8'h19))
      else $error("dead time mapping wrong");
   AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (srst)
      (read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
   COV_OC: cover property (@(posedge clock) disable iff (srst) $rose(oc_fault_q));
   COV_UV: cover property (@(posedge clock) disable iff (srst) $rose(uv_fault_q));
   COV_CFG_WRITE: cover property (@(posedge clock) disable iff (srst) write && !waitrequest);
endmodule : gate_drive_commutation

// >>> gate_drive_pkg.sv
// constants used by the gate drive top, which hands the channel its timings in cycles
// assumes a single 100 MHz clock and a byte-addressed register bus
package gate_drive_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEAD_STEP_NS = 250;
   localparam logic [7:0] DEAD_STEP_CYC = 8'((DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int BLANK_0_NS = 500;
   localparam int BLANK_1_NS = 1000;
   localparam int BLANK_2_NS = 2000;
   localparam int BLANK_3_NS = 4000;
   localparam logic [8:0] BLANK_0_CYC = 9'((BLANK_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] BLANK_1_CYC = 9'((BLANK_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] BLANK_2_CYC = 9'((BLANK_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] BLANK_3_CYC = 9'((BLANK_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // undervoltage qualification time, plain default
   localparam int GATE_BIAS_UNDERVOLT_QUAL_TIME_NS = 1000;
   localparam logic [7:0] UV_QUAL_CYC =
      8'((GATE_BIAS_UNDERVOLT_QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // output enable low for longer than this drops to standby
   localparam int OE_LONG_NS = 1000000;
   localparam int OE_LONG_CYC = OE_LONG_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CONFIG_ADDR = 4'h0;
   localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
   // driver_config_word_2 fields
   localparam int CFG_DEAD_LSB = 0;
   localparam int CFG_BLANK_LSB = 4;
   localparam int CFG_SLEEP_BIT = 8;
   localparam int CFG_UVLO_EN_BIT = 9;
   localparam int CFG_OC_EN_BIT = 10;
   localparam logic [2:0] DEAD_RESET = 3'h7;
   localparam logic [1:0] BLANK_RESET = 2'h3;
   // status fields
   localparam int STS_UV_BIT = 0;
   localparam int STS_OC_BIT = 1;
   localparam int STS_OE_LONG_BIT = 2;
   localparam int STS_BLANK_LSB = 4;
   localparam int STS_HIGH_LSB = 8;
   localparam int STS_LOW_LSB = 12;
endpackage : gate_drive_pkg

// >>> gate_phase_channel.sv
// one half-bridge: interlock, break-before-make delay and blanking timer
// assumes gate inputs synchronous to clock and timings already in cycles
`timescale 1ns/100ps
module gate_phase_channel (
   input wire logic clock,
   input wire logic srst,
   input wire logic enable,
   input wire logic high_in,
   input wire logic low_in,
   input wire logic [7:0] dead_cycles,
   input wire logic [8:0] blank_cycles,
   output logic high_q,
   output logic low_q,
   output logic blank_active
);
   logic want_high;
   logic want_low;
   logic pend_high_q;
   logic pend_low_q;
   logic [7:0] dead_cnt_q;
   logic [8:0] blank_cnt_q;
   logic [7:0] off_cnt_q;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   // both asked on means neither; disable forces both off
   assign want_high = enable & high_in & ~low_in;
   assign want_low = enable & low_in & ~high_in;

   // ----------------------------------------------------------------
   // gate sequencing
   // ----------------------------------------------------------------
   // any change drops the gates at once, then waits out the dead time
   always_ff @(posedge clock) begin
      if (srst) begin
         pend_high_q <= 1'b0;
         pend_low_q <= 1'b0;
         dead_cnt_q <= 8'h00;
         blank_cnt_q <= 9'h000;
         high_q <= 1'b0;
         low_q <= 1'b0;
      end else if (want_high != pend_high_q || want_low != pend_low_q) begin
         pend_high_q <= want_high;
         pend_low_q <= want_low;
         dead_cnt_q <= dead_cycles;
         blank_cnt_q <= 9'h000; // stale blanking would mask the new edge
         high_q <= 1'b0;
         low_q <= 1'b0;
      end else if (dead_cnt_q != 8'h00) begin
         dead_cnt_q <= dead_cnt_q - 8'h01;
      end else if ((pend_high_q & ~high_q) | (pend_low_q & ~low_q)) begin
         high_q <= pend_high_q;
         low_q <= pend_low_q;
         blank_cnt_q <= blank_cycles;
      end else if (blank_cnt_q != 9'h000) begin
         blank_cnt_q <= blank_cnt_q - 9'h001;
      end
   end

   assign blank_active = blank_cnt_q != 9'h000;

   // helper: cycles both gates have been off, saturating
   always_ff @(posedge clock) begin
      if (srst || high_q || low_q) begin
         off_cnt_q <= 8'h00;
      end else if (off_cnt_q != 8'hff) begin
         off_cnt_q <= off_cnt_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_NO_OVERLAP: assert property (@(posedge clock) disable iff (srst)
      !(high_q && low_q)) else $error("both gates of a half-bridge on");
   AST_DEAD_BEFORE_ON: assert property (@(posedge clock) disable iff (srst)
      ($rose(high_q) || $rose(low_q)) |-> $past(off_cnt_q) >= dead_cycles)
      else $error("gate turned on before dead time elapsed");
   AST_BLANK_AT_ON: assert property (@(posedge clock) disable iff (srst)
      ($rose(high_q) || $rose(low_q)) |-> blank_active && blank_cnt_q == blank_cycles)
      else $error("blanking did not start at gate on");
   AST_NO_BLANK_IN_DEAD: assert property (@(posedge clock) disable iff (srst)
      (dead_cnt_q != 8'h00) |-> !blank_active) else $error("blanking ran during dead time");
   AST_DISABLE_OFF: assert property (@(posedge clock) disable iff (srst)
      !enable |=> !high_q && !low_q) else $error("gate on while disabled");
   COV_HIGH_ON: cover property (@(posedge clock) disable iff (srst) $rose(high_q));
   COV_LOW_ON: cover property (@(posedge clock) disable iff (srst) $rose(low_q));
endmodule : gate_phase_channel

// >>> host_pwm_model.sv
// host pwm model: bootstrap, lock and six-step gate patterns on the gate inputs
// assumes the bench moves mode, advance, dir, coast and chop just after a rising edge
`timescale 1ns/100ps
module host_pwm_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic [2:0] mode,
   input wire logic advance,
   input wire logic dir,
   input wire logic coast,
   input wire logic chop,
   output logic [2:0] high_gate_in,
   output logic [2:0] low_gate_in,
   output logic [2:0] bemf_phase
);
   // ---------------------------------------------------------------
   // step tables, states 0..5, bit0 is phase a
   // ---------------------------------------------------------------
   localparam logic [2:0] HI_T [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
   localparam logic [2:0] LO_T [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
   localparam logic [2:0] SENSE_T [6] = '{3'h2, 3'h1, 3'h4, 3'h2, 3'h1, 3'h4};
   logic [2:0] step_q;
   // open-loop step pointer, no rotor feedback; order picks rotation
   always_ff @(posedge clock) begin
      if (srst) begin
         step_q <= 3'h0;
      end else if (advance) begin
         step_q <= dir ? ((step_q == 3'h5) ? 3'h0 : step_q + 3'h1)
            : ((step_q == 3'h0) ? 3'h5 : step_q - 3'h1);
      end
   end
   // pins registered so they only move just after an edge
   always_ff @(posedge clock) begin
      if (srst) begin
         {high_gate_in, low_gate_in, bemf_phase} <= 9'h000;
      end else begin
         case (mode)
            3'h1: {high_gate_in, low_gate_in, bemf_phase} <= {3'h0, 3'h7, 3'h0};
            3'h2: {high_gate_in, low_gate_in, bemf_phase} <= {3'h5, 3'h2, 3'h0};
            3'h3: begin
               // chop-chop off interval drops both switches of the pair for fast decay
               high_gate_in <= (coast || chop) ? 3'h0 : HI_T[step_q];
               low_gate_in <= chop ? 3'h0 : LO_T[step_q];
               bemf_phase <= SENSE_T[step_q];
            end
            // both sides of phase a at once, only when the bench asks for it
            3'h4: {high_gate_in, low_gate_in, bemf_phase} <= {3'h1, 3'h1, 3'h0};
            default: {high_gate_in, low_gate_in, bemf_phase} <= 9'h000;
         endcase
      end
   end
endmodule : host_pwm_model

// >>> gate_drive_commutation_tb.sv
// self-checking bench for the gate drive block with a host pwm model
// assumes the design assertions run alongside; one 100 MHz clock
`timescale 1ns/100ps
module gate_drive_commutation_tb;
   localparam int OE_LONG = 20;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic [31:0] rd;
   logic waitrequest;
   logic output_enable = 1'b1;
   logic [2:0] current_spike = 3'h0;
   logic bias_undervolt = 1'b0;
   logic [2:0] high_gate_in, low_gate_in, high_gate_q, low_gate_q, bemf_phase;
   logic [2:0] mode = 3'h0;
   logic advance = 1'b0;
   logic dir = 1'b1;
   logic coast = 1'b0;
   logic chop = 1'b0;
   int failures = 0;
   int compares = 0;
   int n, dl, st, spd;
   int hi_t[6] = '{1, 2, 2, 4, 4, 1};
   int lo_t[6] = '{4, 4, 1, 1, 2, 2};
   int sense_t[6] = '{2, 1, 4, 2, 1, 4};
   // ---------------------------------------------------------------
   // instances and clock
   // ---------------------------------------------------------------
   gate_drive_commutation #(.OE_LONG_CYC(OE_LONG)) uut (.clock(clock), .srst(srst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .output_enable(output_enable),
      .high_gate_in(high_gate_in), .low_gate_in(low_gate_in),
      .current_spike(current_spike), .bias_undervolt(bias_undervolt),
      .high_gate_q(high_gate_q), .low_gate_q(low_gate_q));
   host_pwm_model host (.clock(clock), .srst(srst), .mode(mode), .advance(advance),
      .dir(dir), .coast(coast), .chop(chop), .high_gate_in(high_gate_in),
      .low_gate_in(low_gate_in),
      .bemf_phase(bemf_phase));
   always #5 clock = ~clock;
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word
   task automatic check_gates(input string what, input logic [5:0] exp);
      check_word(what, {26'h0, exp}, {26'h0, high_gate_q, low_gate_q});
   endtask : check_gates
   // avalon access held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic go(input logic [2:0] m);
      @(posedge clock);
      mode <= m;
   endtask : go
   task automatic edges(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : edges
   // counts edges from the mode change until the gates show exp
   task automatic until_on(input logic [5:0] exp);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while ({high_gate_q, low_gate_q} !== exp && n < 3000);
   endtask : until_on
   // a low-high toggle of enable clears latched faults
   task automatic clear();
      @(posedge clock);
      output_enable <= 1'b0;
      @(posedge clock);
      output_enable <= 1'b1;
   endtask : clear
   function automatic logic [31:0] cfg(input int dt, input int bl, input logic slp);
      return {21'h0, 2'h3, slp, 2'h0, 2'(bl), 1'b0, 3'(dt)};
   endfunction : cfg
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // no half-bridge may ever show both gates on
   always @(posedge clock) begin
      if (!srst) check_word("overlap", 0, {29'h0, high_gate_q & low_gate_q});
   end
   // hang guard, far beyond the few thousand cycles the run needs
   initial begin
      repeat (40000) @(posedge clock);
      failures++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h2dd25f3d));
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, 4'h0, 0);
      check_word("config reset", 32'h637, rd);
      bus(1'b0, 4'h8, 0);
      check_word("unmapped read", 0, rd);
      bus(1'b1, 4'h4, 32'hffff);
      bus(1'b0, 4'h4, 0);
      check_word("status read only", 0, rd);
      n = $urandom;
      bus(1'b1, 4'h0, n);
      bus(1'b0, 4'h0, 0);
      check_word("config rw", n & 32'h737, rd);
      // dead time for every field value, first turn-on from idle
      for (int s = 0; s < 8; s++) begin
         bus(1'b1, 4'h0, cfg(s, 3, 1'b0));
         go(3'h0);
         edges(4);
         go(3'h1);
         until_on(6'h07);
         check_word("dead time", (s + 1) * 25 + 3, n);
      end
      go(3'h2);
      until_on(6'h2a);
      check_word("inverted inputs", 203, n);
      go(3'h4);
      edges(260);
      check_gates("cross conduction", 6'h00);
      // spike held from turn-on must not trip until blanking ends
      for (int b = 0; b < 4; b++) begin
         bus(1'b1, 4'h0, cfg(0, b, 1'b0));
         go(3'h0);
         edges(4);
         go(3'h1);
         until_on(6'h07);
         n = 0;
         @(posedge clock);
         current_spike <= 3'h7;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (low_gate_q !== 3'h0 && n < 600);
         check_word("blank span", 1, n >= (50 << b) - 2 && n <= (50 << b) + 3);
         bus(1'b0, 4'h4, 0);
         check_word("overcurrent flag", 2, rd & 2);
         current_spike <= 3'h0;
         clear();
      end
      // undervolt qualification stretched by the 4 us blanking
      bus(1'b1, 4'h0, cfg(0, 3, 1'b0));
      go(3'h0);
      edges(4);
      go(3'h1);
      until_on(6'h07);
      @(posedge clock);
      bias_undervolt <= 1'b1;
      // lows on and all three phases still blanking
      bus(1'b0, 4'h4, 0);
      check_word("status live", 32'h7070, rd);
      edges(450);
      check_gates("undervolt held", 6'h07);
      edges(80);
      check_gates("undervolt trip", 6'h00);
      bus(1'b0, 4'h4, 0);
      check_word("undervolt flag", 1, rd & 1);
      bias_undervolt <= 1'b0;
      clear();
      // six steps up then down, dwell shrinking like a ramp
      dl = $urandom_range(1, 0);
      // detection switched off: spikes and low bias must not stop the steps
      bus(1'b1, 4'h0, cfg(dl, 0, 1'b0) & 32'h0ff);
      current_spike <= 3'h7;
      bias_undervolt <= 1'b1;
      go(3'h3);
      edges((dl + 1) * 25 + 4);
      st = 0;
      for (int k = 0; k < 12; k++) begin
         @(posedge clock);
         advance <= 1'b1;
         dir <= (k < 6);
         @(posedge clock);
         advance <= 1'b0;
         st = (k < 6) ? (st + 1) % 6 : (st + 5) % 6;
         edges((dl + 1) * 25 + 3);
         check_gates("commutation", {3'(hi_t[st]), 3'(lo_t[st])});
         check_word("sense phase", sense_t[st], {29'h0, bemf_phase});
         edges(20 - k);
      end
      // steady speed at the coast target: chop-chop, aimed 9% lower, stays saturated
      spd = 100;
      @(posedge clock);
      coast <= (spd >= 91);
      edges(2);
      check_gates("coast", {3'h0, 3'(lo_t[st])});
      // speed step under the chop-chop target: the faster chop-chop loop takes over
      spd = 85;
      @(posedge clock);
      coast <= 1'b0;
      chop <= (spd < 91);
      edges(2);
      check_gates("chop", 6'h00);
      @(posedge clock);
      chop <= 1'b0;
      current_spike <= 3'h0;
      bias_undervolt <= 1'b0;
      output_enable <= 1'b0;
      edges(2);
      check_gates("enable low", 6'h00);
      edges(OE_LONG + 5);
      bus(1'b0, 4'h4, 0);
      check_word("long low flag", 4, rd & 7);
      @(posedge clock);
      output_enable <= 1'b1;
      bus(1'b1, 4'h0, cfg(dl, 0, 1'b1));
      edges(80);
      check_gates("sleep", 6'h00);
      give_verdict();
   end
endmodule : gate_drive_commutation_tb
